// ==== pkg/jtag_ram_init_pkg.sv ====
// Shared constants and types for the JTAG RAM initialisation interface
package jtag_ram_init_pkg;

  // Default geometry of the RAM array being loaded
  localparam int DATA_W_DEF = 4;
  localparam int ADDR_W_DEF = 2;
  localparam int NUM_BLK_DEF = 4;

  // Width of the user instruction value from the bridge
  localparam int IR_W = 8;

  // User-defined instruction opcodes
  localparam logic [IR_W-1:0] OP_INIT_RING = 8'h22;
  localparam logic [IR_W-1:0] OP_INIT_ALL = 8'h24;
  localparam logic [IR_W-1:0] OP_ADDR_LOAD = 8'h25;
  localparam logic [IR_W-1:0] OP_BLK_BASE = 8'h30;

  // Synchroniser depth for every pin-side input
  localparam int SYNC_STAGES = 2;

  // Bit positions inside the synchronised input bundle
  localparam int POS_IR = 0;
  localparam int POS_TAP_RST = IR_W;
  localparam int POS_UPDATE = IR_W + 1;
  localparam int POS_SHIFT = IR_W + 2;
  localparam int POS_DCLK = IR_W + 3;
  localparam int POS_SER = IR_W + 4;
  localparam int BUNDLE_W = IR_W + 5;

  // Reset values
  localparam logic RST_BIT = 1'b0;
  localparam logic WCLK_IDLE_INV = 1'b1;
  localparam logic WCLK_IDLE_DIRECT = 1'b0;

  // Decoded instruction modes
  typedef enum logic [2:0] {
    MODE_IDLE = 3'b000,
    MODE_RING = 3'b001,
    MODE_ALL = 3'b010,
    MODE_BLOCK = 3'b011,
    MODE_ADDR = 3'b100
  } mode_t;

endpackage : jtag_ram_init_pkg

// ==== logic/pin_sync.sv ====
// Two-flop synchroniser for a bundle of pin-side levels
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [W-1:0] d_async,
  output logic [W-1:0] d_sync
);
  import jtag_ram_init_pkg::*;

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= d_async;
      sync_reg <= meta_reg;
    end
  end

  assign d_sync = sync_reg;

endmodule : pin_sync

// ==== logic/jtag_ram_init_interface.sv ====
// Loads RAM blocks from words shifted in through the user JTAG bridge
//
// Contract
// - RAM can be preloaded through the user JTAG bridge, not only by logic.
// - The serial-in/parallel-out shift register is as wide as a RAM word.
// - Serial bridge data shifts in, clocked by the data-register shift clock.
// - Shifting happens only while the shift indication is high.
// - A completed word goes to write data through a pipeline register.
// - An internal counter sweeps the RAM addresses; host supplies only data.
// - A separate opcode loads the write address through a second shift register.
// - Matching start opcode runs address counters and asserts selected write enables.
// - With identical data, one enable writes all RAM blocks at once.
// - Each RAM block may be selected by its own distinct opcode.
// - The ring counter selecting blocks is clocked by address generation.
// - After a block's last address, the ring counter steps to the next block.
// - Update indication high marks one data word completely loaded.
// - On update rise, pipeline and counter present new data and address.
// - Write clock is the inverted update indication, giving settle time.
// - The inversion is dropped when RAMs write on the falling edge.
// - Write data, address and chip select are synchronised to the write clock.
`timescale 1ns/100ps
module jtag_ram_init_interface #(
  parameter int DATA_W = jtag_ram_init_pkg::DATA_W_DEF,
  parameter int ADDR_W = jtag_ram_init_pkg::ADDR_W_DEF,
  parameter int NUM_BLK = jtag_ram_init_pkg::NUM_BLK_DEF,
  parameter int ADDR_DEPTH = 2 ** jtag_ram_init_pkg::ADDR_W_DEF,
  parameter bit INVERT_WCLK = 1'b1,
  parameter logic [7:0] OP_RING = jtag_ram_init_pkg::OP_INIT_RING,
  parameter logic [7:0] OP_ALL = jtag_ram_init_pkg::OP_INIT_ALL,
  parameter logic [7:0] OP_ADDR = jtag_ram_init_pkg::OP_ADDR_LOAD,
  parameter logic [7:0] OP_BLK = jtag_ram_init_pkg::OP_BLK_BASE
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic bridge_serial_data_out,
  input wire logic dr_shift_clock,
  input wire logic dr_shift_indication,
  input wire logic dr_update_indication,
  input wire logic [jtag_ram_init_pkg::IR_W-1:0] user_instruction_value,
  input wire logic tap_reset_n,
  output logic serial_return,
  output logic [DATA_W-1:0] wr_data,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [NUM_BLK-1:0] wr_cs,
  output logic wr_en,
  output logic wr_clk,
  output logic init_active
);
  import jtag_ram_init_pkg::*;

  localparam logic [ADDR_W-1:0] ADDR_FIRST = '0;
  localparam logic [ADDR_W-1:0] ADDR_LAST = ADDR_W'(ADDR_DEPTH - 1);
  localparam logic [NUM_BLK-1:0] RING_FIRST = NUM_BLK'(1);
  localparam logic [NUM_BLK-1:0] CS_ALL = '1;
  localparam logic [NUM_BLK-1:0] CS_NONE = '0;
  localparam logic WCLK_IDLE = INVERT_WCLK ? WCLK_IDLE_INV : WCLK_IDLE_DIRECT;

  // Instruction decode
  function automatic mode_t decode_mode(input logic [IR_W-1:0] ir);
    logic [IR_W-1:0] off;
    off = ir - OP_BLK;
    if (ir == OP_RING) begin
      decode_mode = MODE_RING;
    end else if (ir == OP_ALL) begin
      decode_mode = MODE_ALL;
    end else if (ir == OP_ADDR) begin
      decode_mode = MODE_ADDR;
    end else if (ir >= OP_BLK && off < IR_W'(NUM_BLK)) begin
      decode_mode = MODE_BLOCK;
    end else begin
      decode_mode = MODE_IDLE;
    end
  endfunction : decode_mode

  // One-hot select of the block named by a per-block opcode
  function automatic logic [NUM_BLK-1:0] block_select(input logic [IR_W-1:0] ir);
    logic [IR_W-1:0] off;
    off = ir - OP_BLK;
    block_select = CS_NONE;
    for (int i = 0; i < NUM_BLK; i++) begin
      if (off == IR_W'(i)) begin
        block_select[i] = 1'b1;
      end
    end
  endfunction : block_select

  // True for modes that write RAM
  function automatic logic is_write_mode(input mode_t m);
    is_write_mode = (m == MODE_RING) || (m == MODE_ALL) || (m == MODE_BLOCK);
  endfunction : is_write_mode

  // Synchronised pin bundle
  logic [BUNDLE_W-1:0] pins_async;
  logic [BUNDLE_W-1:0] pins_sync;

  assign pins_async[POS_IR +: IR_W] = user_instruction_value;
  assign pins_async[POS_TAP_RST] = tap_reset_n;
  assign pins_async[POS_UPDATE] = dr_update_indication;
  assign pins_async[POS_SHIFT] = dr_shift_indication;
  assign pins_async[POS_DCLK] = dr_shift_clock;
  assign pins_async[POS_SER] = bridge_serial_data_out;

  pin_sync #(
    .W(BUNDLE_W)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .d_async(pins_async),
    .d_sync(pins_sync)
  );

  logic [IR_W-1:0] ir_s;
  logic tap_rst_n_s;
  logic upd_s;
  logic shift_s;
  logic dclk_s;
  logic ser_s;

  assign ir_s = pins_sync[POS_IR +: IR_W];
  assign tap_rst_n_s = pins_sync[POS_TAP_RST];
  assign upd_s = pins_sync[POS_UPDATE];
  assign shift_s = pins_sync[POS_SHIFT];
  assign dclk_s = pins_sync[POS_DCLK];
  assign ser_s = pins_sync[POS_SER];

  // Edge detection on the synchronised shift clock and update
  logic dclk_d_reg;
  logic upd_d_reg;
  logic dclk_rise;
  logic upd_rise;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dclk_d_reg <= RST_BIT;
      upd_d_reg <= RST_BIT;
    end else begin
      dclk_d_reg <= dclk_s;
      upd_d_reg <= upd_s;
    end
  end

  assign dclk_rise = dclk_s & ~dclk_d_reg;
  assign upd_rise = upd_s & ~upd_d_reg;

  // Current mode from the instruction value
  mode_t mode_reg;
  mode_t mode_next;
  logic [NUM_BLK-1:0] blk_sel_reg;

  assign mode_next = decode_mode(ir_s);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= MODE_IDLE;
      blk_sel_reg <= CS_NONE;
    end else begin
      mode_reg <= mode_next;
      blk_sel_reg <= block_select(ir_s);
    end
  end

  logic write_mode;

  assign write_mode = is_write_mode(mode_reg);

  // Data shift register, one RAM word wide
  logic [DATA_W-1:0] data_sr_reg;
  logic data_shift_en;

  assign data_shift_en = dclk_rise & shift_s & write_mode;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      data_sr_reg <= '0;
    end else if (data_shift_en) begin
      data_sr_reg <= {ser_s, data_sr_reg[DATA_W-1:1]};
    end
  end

  // Address shift register for the address-load opcode
  logic [ADDR_W-1:0] addr_sr_reg;
  logic addr_shift_en;

  assign addr_shift_en = dclk_rise & shift_s & (mode_reg == MODE_ADDR);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      addr_sr_reg <= '0;
    end else if (addr_shift_en) begin
      addr_sr_reg <= {ser_s, addr_sr_reg[ADDR_W-1:1]};
    end
  end

  // Bit leaving the active shift register, back towards the bridge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      serial_return <= RST_BIT;
    end else if (mode_reg == MODE_ADDR) begin
      serial_return <= addr_sr_reg[0];
    end else begin
      serial_return <= data_sr_reg[0];
    end
  end

  // Address counter sweeping the RAM range
  logic [ADDR_W-1:0] addr_cnt_reg;
  logic [ADDR_W-1:0] addr_cnt_next;
  logic word_done;
  logic block_done;

  assign word_done = upd_rise & write_mode;
  assign block_done = word_done & (addr_cnt_reg == ADDR_LAST);

  always_comb begin
    addr_cnt_next = addr_cnt_reg;
    if (upd_rise && mode_reg == MODE_ADDR) begin
      addr_cnt_next = addr_sr_reg;
    end else if (block_done) begin
      addr_cnt_next = ADDR_FIRST;
    end else if (word_done) begin
      addr_cnt_next = addr_cnt_reg + ADDR_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      addr_cnt_reg <= ADDR_FIRST;
    end else if (!tap_rst_n_s) begin
      addr_cnt_reg <= ADDR_FIRST;
    end else begin
      addr_cnt_reg <= addr_cnt_next;
    end
  end

  // Ring counter stepped by the address generator
  logic [NUM_BLK-1:0] ring_reg;
  logic ring_step;

  assign ring_step = block_done & (mode_reg == MODE_RING);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ring_reg <= RING_FIRST;
    end else if (!tap_rst_n_s) begin
      ring_reg <= RING_FIRST;
    end else if (ring_step) begin
      ring_reg <= {ring_reg[NUM_BLK-2:0], ring_reg[NUM_BLK-1]};
    end
  end

  // Chip select for the current word
  logic [NUM_BLK-1:0] cs_now;

  always_comb begin
    unique case (mode_reg)
      MODE_RING: cs_now = ring_reg;
      MODE_ALL: cs_now = CS_ALL;
      MODE_BLOCK: cs_now = blk_sel_reg;
      MODE_ADDR: cs_now = CS_NONE;
      MODE_IDLE: cs_now = CS_NONE;
      default: cs_now = CS_NONE;
    endcase
  end

  // Pipeline registers presenting word, address and select on update
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_data <= '0;
      wr_addr <= ADDR_FIRST;
      wr_cs <= CS_NONE;
    end else if (word_done) begin
      wr_data <= data_sr_reg;
      wr_addr <= addr_cnt_reg;
      wr_cs <= cs_now;
    end
  end

  // Write enable follows the start opcode match
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_en <= RST_BIT;
      init_active <= RST_BIT;
    end else begin
      wr_en <= write_mode & (cs_now != CS_NONE);
      init_active <= write_mode;
    end
  end

  // Write clock from the update indication
  logic wr_clk_next;

  always_comb begin
    if (!write_mode) begin
      wr_clk_next = WCLK_IDLE;
    end else if (INVERT_WCLK) begin
      wr_clk_next = ~upd_s;
    end else begin
      wr_clk_next = upd_s;
    end
  end

  // Same edge as the pipeline so data leads the active write edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_clk <= WCLK_IDLE;
    end else begin
      wr_clk <= wr_clk_next;
    end
  end

endmodule : jtag_ram_init_interface

// ==== dv/user_jtag_bridge_model.sv ====
// Behavioural user JTAG bridge driving the pin side
`timescale 1ns/100ps
module user_jtag_bridge_model (
  output logic bridge_serial_data_out,
  output logic dr_shift_clock,
  output logic dr_shift_indication,
  output logic dr_update_indication,
  output logic [7:0] user_instruction_value
);
  initial begin
    bridge_serial_data_out = 1'b0;
    dr_shift_clock = 1'b0;
    dr_shift_indication = 1'b0;
    dr_update_indication = 1'b0;
    user_instruction_value = 8'h00;
  end
  // Opcode picks run, block or address load
  task set_ir(input logic [7:0] v);
    user_instruction_value = v;
  endtask : set_ir
  // LSB first, clock idle low between frames
  task shift(input logic [7:0] v, input int n, input logic sh, input int hp);
    for (int i = 0; i < n; i++) begin
      bridge_serial_data_out = v[i];
      dr_shift_indication = sh;
      #hp dr_shift_clock = 1'b1;
      #hp dr_shift_clock = 1'b0;
    end
    dr_shift_indication = 1'b0;
    bridge_serial_data_out = ~bridge_serial_data_out;
  endtask : shift
  // High only in the update state
  task set_upd(input logic v);
    dr_update_indication = v;
  endtask : set_upd
endmodule : user_jtag_bridge_model

// ==== dv/jtag_ram_init_asserts.sv ====
// Port checks for the JTAG RAM initialisation interface
`timescale 1ns/100ps
module jtag_ram_init_checks #(
  parameter int DATA_W = 4,
  parameter int ADDR_W = 2,
  parameter int NUM_BLK = 4,
  parameter int ADDR_DEPTH = 4,
  parameter logic [7:0] OP_RING = 8'h22
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic dr_update_indication,
  input wire logic [jtag_ram_init_pkg::IR_W-1:0] user_instruction_value,
  input wire logic tap_reset_n,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [NUM_BLK-1:0] wr_cs,
  input wire logic wr_en,
  input wire logic wr_clk,
  input wire logic init_active
);
  import jtag_ram_init_pkg::*;
  logic [ADDR_W-1:0] a_prev_reg;
  logic [NUM_BLK-1:0] cs_prev_reg;
  logic seq_reg;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // Last load of an unbroken write run
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      a_prev_reg <= '0;
      cs_prev_reg <= '0;
      seq_reg <= 1'b0;
    end else if (!init_active || !tap_reset_n) begin
      seq_reg <= 1'b0;
    end else if ($fell(wr_clk)) begin
      a_prev_reg <= wr_addr;
      cs_prev_reg <= wr_cs;
      seq_reg <= 1'b1;
    end
  end
  wclk_fall_a: assert property (
    $rose(dr_update_indication) && init_active |-> ##3 !wr_clk)
    else $error("write clock missed update rise");
  wclk_rise_a: assert property (
    $fell(dr_update_indication) && init_active |-> ##3 wr_clk)
    else $error("write clock missed update fall");
  idle_clk_a: assert property (
    !init_active && !$past(init_active) |-> wr_clk)
    else $error("write clock not idle");
  out_hold_a: assert property (
    !$fell(wr_clk) |-> $stable(wr_data) && $stable(wr_addr))
    else $error("outputs moved without load");
  en_cs_a: assert property (
    (wr_en == init_active) && (!$fell(wr_clk) || wr_cs != '0))
    else $error("enable without selection");
  addr_step_a: assert property (
    $fell(wr_clk) && seq_reg |-> wr_addr == ADDR_W'(a_prev_reg + 1'b1))
    else $error("address did not step");
  ring_step_a: assert property (
    $fell(wr_clk) && seq_reg && user_instruction_value == OP_RING |-> wr_cs ==
      (a_prev_reg == ADDR_W'(ADDR_DEPTH - 1) ?
      {cs_prev_reg[NUM_BLK-2:0], cs_prev_reg[NUM_BLK-1]} : cs_prev_reg))
    else $error("ring select wrong");
  ir_run_a: assert property (
    (user_instruction_value == OP_RING) [*5] |-> init_active && wr_en)
    else $error("start opcode not decoded");
  cover property ($fell(wr_clk) && &wr_cs);
  cover property ($fell(wr_clk) && seq_reg && a_prev_reg == ADDR_W'(ADDR_DEPTH - 1));
  cover property ($fell(tap_reset_n));
endmodule : jtag_ram_init_checks
bind jtag_ram_init_interface jtag_ram_init_checks #(
  .DATA_W(DATA_W), .ADDR_W(ADDR_W), .NUM_BLK(NUM_BLK),
  .ADDR_DEPTH(ADDR_DEPTH), .OP_RING(OP_RING)
) checks (
  .sys_clk(sys_clk), .nrst(nrst), .dr_update_indication(dr_update_indication),
  .user_instruction_value(user_instruction_value), .tap_reset_n(tap_reset_n),
  .wr_data(wr_data), .wr_addr(wr_addr), .wr_cs(wr_cs), .wr_en(wr_en),
  .wr_clk(wr_clk), .init_active(init_active)
);

// ==== dv/tb_jtag_ram_init_interface.sv ====
// Self-checking bench for the JTAG RAM initialisation interface
`timescale 1ns/100ps
module tb_jtag_ram_init_interface;
  import jtag_ram_init_pkg::*;
  typedef struct {
    logic [7:0] ir;
    logic [3:0] w;
    logic [1:0] a;
    logic [3:0] c;
  } row_t;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  wire sd, dck, dsh, dup;
  logic tr_n = 1'b1;
  wire [7:0] ir;
  logic sret, we, wc, act;
  logic [3:0] wd, cs;
  logic [1:0] wa;
  int failures = 0;
  int n_checks = 0;
  row_t rows [10] = '{
    '{OP_INIT_RING, 4'h5, 2'h0, 4'h1}, '{OP_INIT_RING, 4'ha, 2'h1, 4'h1},
    '{OP_INIT_RING, 4'h3, 2'h2, 4'h1}, '{OP_INIT_RING, 4'hc, 2'h3, 4'h1},
    '{OP_INIT_RING, 4'h6, 2'h0, 4'h2}, '{OP_INIT_ALL, 4'h9, 2'h1, 4'hf},
    '{OP_BLK_BASE, 4'he, 2'h2, 4'h1}, '{OP_BLK_BASE + 8'h01, 4'h1, 2'h3, 4'h2},
    '{OP_BLK_BASE + 8'h02, 4'h7, 2'h0, 4'h4}, '{OP_BLK_BASE + 8'h03, 4'h8, 2'h1, 4'h8}
  };
  always #50 sys_clk = ~sys_clk;
  user_jtag_bridge_model br (
    .bridge_serial_data_out(sd), .dr_shift_clock(dck), .dr_shift_indication(dsh),
    .dr_update_indication(dup), .user_instruction_value(ir)
  );
  jtag_ram_init_interface dut (
    .sys_clk(sys_clk), .nrst(nrst), .bridge_serial_data_out(sd), .dr_shift_clock(dck),
    .dr_shift_indication(dsh), .dr_update_indication(dup), .user_instruction_value(ir),
    .tap_reset_n(tr_n), .serial_return(sret), .wr_data(wd), .wr_addr(wa), .wr_cs(cs),
    .wr_en(we), .wr_clk(wc), .init_active(act)
  );
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task chkb(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %b got %b", nm, e, g);
    end
  endtask : chkb
  task chkv(input string nm, input logic [3:0] e, input logic [3:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chkv
  task close_out;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  task rst_chk;
    chkv("wr_data", 4'h0, wd);
    chkv("wr_cs", 4'h0, cs);
    chkb("wr_clk", 1'b1, wc);
    chkb("init_active", 1'b0, act);
  endtask : rst_chk
  // Shift a word, then update and watch the write
  task put(input logic [7:0] v, input int n, input int hp, input logic [3:0] w,
      input logic [1:0] a, input logic [3:0] c);
    br.shift(v, n, 1'b1, hp);
    cyc(4);
    chkb("serial_return", w[0], sret);
    br.set_upd(1'b1);
    cyc(5);
    chkv("wr_data", w, wd);
    chkv("wr_addr", {2'b00, a}, {2'b00, wa});
    chkv("wr_cs", c, cs);
    chkb("wr_en", 1'b1, we);
    chkb("wr_clk", 1'b0, wc);
    br.set_upd(1'b0);
    cyc(5);
    chkb("wr_clk", 1'b1, wc);
  endtask : put
  // Update outside a write mode must not write
  task idle_upd(input logic [3:0] w);
    br.set_upd(1'b1);
    cyc(5);
    chkb("wr_clk", 1'b1, wc);
    chkv("wr_data", w, wd);
    br.set_upd(1'b0);
    cyc(5);
  endtask : idle_upd
  task set_mode(input logic [7:0] v);
    br.set_ir(v);
    cyc(5);
  endtask : set_mode
  initial begin
    #1_000_000;
    failures++;
    close_out();
  end
  initial begin
    cyc(8);
    rst_chk();
    nrst = 1'b1;
    cyc(3);
    foreach (rows[i]) begin
      set_mode(rows[i].ir);
      put({4'h0, rows[i].w}, 4, 400, rows[i].w, rows[i].a, rows[i].c);
    end
    set_mode(OP_INIT_ALL);
    put(8'h2d, 6, 400, 4'hb, 2'h2, 4'hf);
    br.shift(8'h00, 4, 1'b0, 400);
    cyc(4);
    chkb("serial_return", 1'b1, sret);
    set_mode(OP_ADDR_LOAD);
    br.shift(8'h02, 2, 1'b1, 400);
    cyc(4);
    chkb("serial_return", 1'b0, sret);
    idle_upd(4'hb);
    set_mode(OP_INIT_ALL);
    put(8'h04, 4, 400, 4'h4, 2'h2, 4'hf);
    set_mode(8'h00);
    chkb("init_active", 1'b0, act);
    chkb("wr_en", 1'b0, we);
    br.shift(8'h0f, 4, 1'b1, 400);
    idle_upd(4'h4);
    tr_n = 1'b0;
    cyc(5);
    tr_n = 1'b1;
    set_mode(OP_INIT_RING);
    put(8'h03, 4, 400, 4'h3, 2'h0, 4'h1);
    nrst = 1'b0;
    cyc(2);
    rst_chk();
    nrst = 1'b1;
    cyc(3);
    close_out();
  end
endmodule : tb_jtag_ram_init_interface
